// file: dsef_avalon_slave.sv
// Avalon-MM slave front end: one-wait-state handshake and write/read strobes
module dsef_avalon_slave
    import dsef_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    output logic o_waitrequest,
    output logic o_wr_stb,
    output logic o_rd_stb
);
    logic done_r; // Access answered this cycle
    wire req = i_read | i_write;
    // Waitrequest drops one cycle after the request rises, then the access completes
    assign o_waitrequest = req & ~done_r;
    assign o_wr_stb = i_write & done_r & i_clk_en;
    assign o_rd_stb = i_read & done_r & i_clk_en;

    // Toggle so back-to-back requests each get one wait state
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_r <= 1'b0;
        end else if (i_clk_en) begin
            done_r <= req & ~done_r;
        end
    end
endmodule

// file: dsef_pkg.sv
// Package for the DMA status event flag block: register map, bit positions, state codes
package dsef_pkg;
    // Register byte addresses (word aligned)
    localparam logic [3:0] DSEF_OFF_STATUS = 4'h0;
    localparam logic [3:0] DSEF_OFF_MASK = 4'h4;
    localparam logic [3:0] DSEF_OFF_CTRL = 4'h8;
    // Status bit positions
    localparam int DSEF_B_TX_DONE = 0;
    localparam int DSEF_B_TX_HALT = 1;
    localparam int DSEF_B_TX_BUF = 2;
    localparam int DSEF_B_TX_JAB = 3;
    localparam int DSEF_B_TX_UNF = 5;
    localparam int DSEF_B_RX_DONE = 6;
    localparam int DSEF_B_RX_BUF = 7;
    localparam int DSEF_B_RX_HALT = 8;
    localparam int DSEF_B_RX_WDT = 9;
    localparam int DSEF_B_ABN = 15;
    localparam int DSEF_B_NRM = 16;
    localparam int DSEF_B_TS_LO = 20;
    localparam int DSEF_B_RS_LO = 17;
    // Sticky bits 0-3 and 5-9 that clear on write of one
    localparam logic [16:0] DSEF_W1C_MASK = 17'h003ef;
    localparam logic [16:0] DSEF_NRM_SRC = 17'h00045;
    localparam logic [16:0] DSEF_ABN_SRC = 17'h003aa;
    // Reset values
    localparam logic [31:0] DSEF_STATUS_RST = 32'hfc000000;
    localparam logic [16:0] DSEF_MASK_RST = 17'h00000;
    // Descriptor status word bits
    localparam int DSEF_TDS_UNF = 1;
    localparam int DSEF_TDS_JAB = 14;
    // Control register bits
    localparam int DSEF_C_RX_START = 0;
    localparam int DSEF_C_TX_START = 1;
    localparam int DSEF_C_TX_AUTOPOLL = 2;

    // Receive process states, gray along start->fetch->wait->close
    typedef enum logic [2:0] {
        DSEF_RX_STOP = 3'h0,
        DSEF_RX_FETCH = 3'h1,
        DSEF_RX_WAIT = 3'h3,
        DSEF_RX_CLOSE = 3'h2,
        DSEF_RX_SUSP = 3'h6
    } dsef_rx_state_t;
    // Transmit process states
    typedef enum logic [2:0] {
        DSEF_TX_STOP = 3'h0,
        DSEF_TX_FETCH = 3'h1,
        DSEF_TX_SEND = 3'h3,
        DSEF_TX_CLOSE = 3'h2,
        DSEF_TX_SUSP = 3'h6
    } dsef_tx_state_t;

    // Engine event inputs
    typedef struct packed {
        logic rx_desc_fetched;
        logic rx_desc_host_owned;
        logic rx_frame_done;
        logic rx_frame_seen;
        logic rx_watchdog;
        logic rx_stop_cmd;
        logic tx_desc_fetched;
        logic tx_desc_host_owned;
        logic tx_frame_done;
        logic tx_fifo_underflow;
        logic tx_jabber;
        logic tx_stop_cmd;
        logic rx_poll;
        logic tx_poll;
    } dsef_evt_t;
endpackage

// file: dsef_top.sv
// DMA status event flags: sticky status, process state tracking, interrupt and register bus
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
module dsef_top
    import dsef_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire dsef_evt_t i_evt,
    output logic o_irq,
    output logic [31:0] o_tx_descriptor_status_word,
    output logic o_tx_desc_status_wr,
    output logic o_rx_desc_status_wr,
    output logic o_rx_running,
    output logic o_tx_running
);
    // Register state
    logic [16:0] sticky_r; // Sticky event bits, summaries excluded
    logic [16:0] mask_r; // Interrupt enables, same layout
    logic [2:0] ctrl_r; // Start commands and auto poll
    logic [31:0] rdata_r;
    logic irq_r;
    logic [31:0] tdes_r;
    logic tdes_wr_r;
    logic rdes_wr_r;
    logic rx_seen_dev_r; // Previous receive fetch found a device-owned descriptor
    dsef_rx_state_t rx_st_r, rx_st_nxt;
    dsef_tx_state_t tx_st_r, tx_st_nxt;

    // Bus handshake
    logic wr_stb, rd_stb;
    dsef_avalon_slave u_slave (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_address(i_avs_address),
        .i_read(i_avs_read),
        .i_write(i_avs_write),
        .o_waitrequest(o_avs_waitrequest),
        .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb)
    );

    // Address decode
    wire sel_status = (i_avs_address == DSEF_OFF_STATUS);
    wire sel_mask = (i_avs_address == DSEF_OFF_MASK);
    wire sel_ctrl = (i_avs_address == DSEF_OFF_CTRL);
    wire wr_status = wr_stb & sel_status;
    wire wr_mask = wr_stb & sel_mask;
    wire wr_ctrl = wr_stb & sel_ctrl;
    // Only bits 0-3 and 5-9 are writable as clears; all other bits are dropped here
    wire [16:0] clr_bits = wr_status ? (i_avs_writedata[16:0] & DSEF_W1C_MASK) : 17'h00000;

    // Start commands: a rising control bit starts the process, a falling one stops it
    wire rx_start = wr_ctrl & i_avs_writedata[DSEF_C_RX_START] & ~ctrl_r[DSEF_C_RX_START];
    wire tx_start = wr_ctrl & i_avs_writedata[DSEF_C_TX_START] & ~ctrl_r[DSEF_C_TX_START];
    wire rx_stop_sw = wr_ctrl & ~i_avs_writedata[DSEF_C_RX_START] & ctrl_r[DSEF_C_RX_START];
    wire tx_stop_sw = wr_ctrl & ~i_avs_writedata[DSEF_C_TX_START] & ctrl_r[DSEF_C_TX_START];
    wire autopoll = ctrl_r[DSEF_C_TX_AUTOPOLL];

    // Receive event qualification
    wire rx_active = (rx_st_r != DSEF_RX_STOP);
    wire rx_owned_fetch = i_evt.rx_desc_fetched & i_evt.rx_desc_host_owned & rx_active;
    wire rx_dev_fetch = i_evt.rx_desc_fetched & ~i_evt.rx_desc_host_owned & rx_active;
    wire ev_rx_buf = rx_owned_fetch & rx_seen_dev_r;
    wire ev_rx_done = i_evt.rx_frame_done & (rx_st_r == DSEF_RX_WAIT);
    wire rx_resume = (rx_st_r == DSEF_RX_SUSP) & (i_evt.rx_poll | i_evt.rx_frame_seen);
    wire rx_stop_req = i_evt.rx_stop_cmd | rx_stop_sw;

    // Receive process next state
    always_comb begin
        rx_st_nxt = rx_st_r;
        unique case (rx_st_r)
            DSEF_RX_STOP: begin
                if (rx_start) rx_st_nxt = DSEF_RX_FETCH;
            end
            DSEF_RX_FETCH: begin
                // Host-owned descriptor parks the receive process
                if (rx_owned_fetch) rx_st_nxt = DSEF_RX_SUSP;
                else if (rx_dev_fetch) rx_st_nxt = DSEF_RX_WAIT;
            end
            DSEF_RX_WAIT: begin
                if (ev_rx_done) rx_st_nxt = DSEF_RX_CLOSE;
            end
            DSEF_RX_CLOSE: begin
                // Status posted; stay running and fetch the next one
                rx_st_nxt = DSEF_RX_FETCH;
            end
            DSEF_RX_SUSP: begin
                if (rx_resume) rx_st_nxt = DSEF_RX_FETCH;
            end
            default: rx_st_nxt = DSEF_RX_STOP;
        endcase
        if (rx_stop_req) rx_st_nxt = DSEF_RX_STOP;
    end

    // Entry into stopped, from any active state
    wire ev_rx_halt = rx_active & (rx_st_nxt == DSEF_RX_STOP);

    // Transmit event qualification
    wire tx_active = (tx_st_r != DSEF_TX_STOP);
    wire ev_tx_buf = (tx_st_r == DSEF_TX_FETCH) & i_evt.tx_desc_fetched & i_evt.tx_desc_host_owned;
    wire ev_tx_unf = (tx_st_r == DSEF_TX_SEND) & i_evt.tx_fifo_underflow;
    wire ev_tx_jab = tx_active & i_evt.tx_jabber;
    wire ev_tx_done = (tx_st_r == DSEF_TX_SEND) & i_evt.tx_frame_done;
    // Auto polling stands in for the host's poll demand
    wire tx_resume = (tx_st_r == DSEF_TX_SUSP) & (i_evt.tx_poll | autopoll);
    wire tx_stop_req = i_evt.tx_stop_cmd | tx_stop_sw;

    // Transmit process next state; jabber outranks every other transition
    always_comb begin
        tx_st_nxt = tx_st_r;
        unique case (tx_st_r)
            DSEF_TX_STOP: begin
                if (tx_start) tx_st_nxt = DSEF_TX_FETCH;
            end
            DSEF_TX_FETCH: begin
                if (ev_tx_buf) tx_st_nxt = DSEF_TX_SUSP;
                else if (i_evt.tx_desc_fetched) tx_st_nxt = DSEF_TX_SEND;
            end
            DSEF_TX_SEND: begin
                if (ev_tx_unf) tx_st_nxt = DSEF_TX_SUSP;
                else if (ev_tx_done) tx_st_nxt = DSEF_TX_CLOSE;
            end
            DSEF_TX_CLOSE: begin
                tx_st_nxt = DSEF_TX_FETCH;
            end
            DSEF_TX_SUSP: begin
                if (tx_resume) tx_st_nxt = DSEF_TX_FETCH;
            end
            default: tx_st_nxt = DSEF_TX_STOP;
        endcase
        if (ev_tx_jab | tx_stop_req) tx_st_nxt = DSEF_TX_STOP;
    end

    wire ev_tx_halt = tx_active & (tx_st_nxt == DSEF_TX_STOP);

    // Per-bit event vector in status layout
    logic [16:0] set_bits;
    assign set_bits = {7'h00, i_evt.rx_watchdog, ev_rx_halt, ev_rx_buf, ev_rx_done,
                       ev_tx_unf, 1'b0, ev_tx_jab, ev_tx_buf, ev_tx_halt, ev_tx_done};

    // Sticky bits: a set in the clearing cycle wins so no event is lost
    logic [16:0] sticky_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 17; gi++) begin : g_sticky
            assign sticky_nxt[gi] = DSEF_W1C_MASK[gi] & (set_bits[gi] | (sticky_r[gi] & ~clr_bits[gi]));
        end
    endgenerate

    // Summaries are recomputed from the sticky bits, never stored separately
    wire nrm_sum = |(sticky_r & DSEF_NRM_SRC);
    wire abn_sum = |(sticky_r & DSEF_ABN_SRC);
    wire [31:0] status_view = {DSEF_STATUS_RST[31:23], tx_st_r, rx_st_r, nrm_sum, abn_sum,
                               sticky_r[14:0]};
    wire irq_nxt = |(sticky_nxt & mask_r);

    // Read mux; unmapped addresses read zero
    wire [31:0] rdata_nxt = sel_status ? status_view :
                            sel_mask ? {15'h0000, mask_r} :
                            sel_ctrl ? {29'h00000000, ctrl_r} : 32'h00000000;

    // Transmit descriptor status word written back on underflow or jabber, not on completion
    wire [31:0] tdes_nxt = {17'h00000, ev_tx_jab, 12'h000, ev_tx_unf, 1'b0};

    // Register and state update
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sticky_r <= DSEF_STATUS_RST[16:0];
            mask_r <= DSEF_MASK_RST;
            ctrl_r <= 3'h0;
            rx_st_r <= DSEF_RX_STOP;
            tx_st_r <= DSEF_TX_STOP;
            rx_seen_dev_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else if (i_clk_en) begin
            sticky_r <= sticky_nxt;
            rx_st_r <= rx_st_nxt;
            tx_st_r <= tx_st_nxt;
            // Re-arm the buffer flag once a device-owned descriptor is seen
            if (rx_dev_fetch) rx_seen_dev_r <= 1'b1;
            else if (rx_owned_fetch) rx_seen_dev_r <= 1'b0;
            if (wr_mask) mask_r <= i_avs_writedata[16:0];
            if (wr_ctrl) ctrl_r <= i_avs_writedata[2:0];
            if (rd_stb) rdata_r <= rdata_nxt;
        end
    end

    // Registered outputs: interrupt and descriptor write-back pulses
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_r <= 1'b0;
            tdes_r <= 32'h00000000;
            tdes_wr_r <= 1'b0;
            rdes_wr_r <= 1'b0;
        end else if (i_clk_en) begin
            irq_r <= irq_nxt;
            tdes_wr_r <= ev_tx_unf | ev_tx_jab;
            rdes_wr_r <= ev_rx_done;
            if (ev_tx_unf | ev_tx_jab) tdes_r <= tdes_nxt;
        end
    end

    // Read data comes straight from the mux in the answering cycle; rdata_r holds it afterwards
    assign o_avs_readdata = rd_stb ? rdata_nxt : rdata_r;
    assign o_irq = irq_r;
    assign o_tx_descriptor_status_word = tdes_r;
    assign o_tx_desc_status_wr = tdes_wr_r;
    assign o_rx_desc_status_wr = rdes_wr_r;
    assign o_rx_running = (rx_st_r != DSEF_RX_STOP) & (rx_st_r != DSEF_RX_SUSP);
    assign o_tx_running = (tx_st_r != DSEF_TX_STOP) & (tx_st_r != DSEF_TX_SUSP);
endmodule

// file: dsef_top_assertions.sv
// Assertion checker for the DMA status event flag block
module dsef_top_checker
    import dsef_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire dsef_evt_t i_evt,
    input wire logic o_irq,
    input wire logic [31:0] o_tx_descriptor_status_word,
    input wire logic o_tx_desc_status_wr,
    input wire logic o_rx_desc_status_wr,
    input wire logic o_rx_running,
    input wire logic o_tx_running
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    // Status read completing in this cycle; readdata only stands here
    wire logic st_rd = i_avs_read && !o_avs_waitrequest && i_avs_address == DSEF_OFF_STATUS;
    chk_one_wait: assert property (
        $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("bus answer not after one wait state");
    chk_status_fixed: assert property (
        st_rd |-> o_avs_readdata[31:23] == 9'h1f8 && !o_avs_readdata[4])
        else $error("status constant bits wrong");
    chk_normal_sum: assert property (
        st_rd |-> o_avs_readdata[DSEF_B_NRM] == |(o_avs_readdata[16:0] & DSEF_NRM_SRC))
        else $error("normal summary wrong");
    chk_abnormal_sum: assert property (
        st_rd |-> o_avs_readdata[DSEF_B_ABN] == |(o_avs_readdata[16:0] & DSEF_ABN_SRC))
        else $error("abnormal summary wrong");
    chk_rx_frame_wr: assert property (
        o_rx_desc_status_wr |-> $past(i_evt.rx_frame_done) && o_rx_running)
        else $error("rx descriptor write without frame");
    chk_rx_suspend: assert property (
        i_evt.rx_desc_fetched && i_evt.rx_desc_host_owned && o_rx_running |=> !o_rx_running)
        else $error("rx not suspended on host descriptor");
    chk_tx_suspend: assert property (
        i_evt.tx_desc_fetched && i_evt.tx_desc_host_owned && o_tx_running |=> !o_tx_running)
        else $error("tx not suspended on host descriptor");
    chk_unf_mark: assert property (
        i_evt.tx_fifo_underflow && o_tx_running |=>
        !o_tx_running && o_tx_desc_status_wr && o_tx_descriptor_status_word[DSEF_TDS_UNF])
        else $error("underflow not marked or not suspended");
    chk_jab_stop: assert property (
        i_evt.tx_jabber && o_tx_running |=>
        !o_tx_running && o_tx_desc_status_wr && o_tx_descriptor_status_word[DSEF_TDS_JAB])
        else $error("jabber not marked or not stopped");
endmodule

bind dsef_top dsef_top_checker u_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_evt(i_evt), .o_irq(o_irq), .o_tx_descriptor_status_word(o_tx_descriptor_status_word),
    .o_tx_desc_status_wr(o_tx_desc_status_wr), .o_rx_desc_status_wr(o_rx_desc_status_wr),
    .o_rx_running(o_rx_running), .o_tx_running(o_tx_running));

// file: dsef_top_test.sv
// Self-checking testbench for the DMA status event flag block
module dsef_top_test
    import dsef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, irq, waitreq, dwr_tx, dwr_rx, rx_run, tx_run;
    logic en = 1'b1; // Clock enable, dropped once to check that state freezes
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, dword, rv;
    dsef_evt_t evt = '0;
    int bad_count = 0, checks_done = 0;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    logic [16:0] fl = 17'h0, msk = 17'h0; // Expected sticky flags and mask
    logic [2:0] rs = 3'h0, ts = 3'h0; // Expected process states
    integer seed = 32'h90cd;
    always #5 clk = ~clk;
    // Clock enable driven by the bench so that a frozen cycle can be checked
    dsef_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(en), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_evt(evt), .o_irq(irq), .o_tx_descriptor_status_word(dword), .o_tx_desc_status_wr(dwr_tx),
        .o_rx_desc_status_wr(dwr_rx), .o_rx_running(rx_run), .o_tx_running(tx_run));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Monitor: every completed read takes the oldest expectation
    always @(posedge clk) begin
        if (rd === 1'b1 && waitreq === 1'b0) begin
            if (exp_q.size() == 0) check(rdata, 32'hx, "unexpected read");
            else check(rdata, exp_q.pop_front(), "readdata");
        end
    end
    // Avalon master: hold everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdx(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Status read with summaries built from the flags, plus the interrupt level
    task automatic rds;
        rdx(DSEF_OFF_STATUS, {9'h1f8, ts, rs, |(fl & DSEF_NRM_SRC), |(fl & DSEF_ABN_SRC), fl[14:0]});
        check({31'h0, irq}, {31'h0, |(fl & msk)}, "irq");
        check({30'h0, rx_run, tx_run}, {30'h0, rs != 3'h0 && rs != 3'h6, ts != 3'h0 && ts != 3'h6}, "running");
    endtask
    // One-cycle event pulse, then a few cycles to let state settle
    task automatic ev(input dsef_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rds();
        rdx(4'hc, 32'h0);
        rv = $random(seed);
        bus(1'b1, 4'hc, rv);
        bus(1'b1, DSEF_OFF_STATUS, rv & 32'hfffe0000);
        rds();
        rv = $random(seed);
        bus(1'b1, DSEF_OFF_MASK, rv);
        rdx(DSEF_OFF_MASK, {15'h0, rv[16:0]});
        msk = 17'h40;
        bus(1'b1, DSEF_OFF_MASK, 32'h40);
        $display("test registers done");
        bus(1'b1, DSEF_OFF_CTRL, 32'h3);
        rs = 3'h1;
        ts = 3'h1;
        rds();
        ev('{rx_desc_fetched: 1'b1, default: 1'b0});
        rs = 3'h3;
        rds();
        ev('{rx_frame_done: 1'b1, default: 1'b0});
        fl[6] = 1'b1;
        rs = 3'h1;
        rds();
        msk = 17'h0;
        bus(1'b1, DSEF_OFF_MASK, 32'h0);
        rds();
        ev('{rx_desc_fetched: 1'b1, rx_desc_host_owned: 1'b1, default: 1'b0});
        fl[7] = 1'b1;
        rs = 3'h6;
        rds();
        bus(1'b1, DSEF_OFF_STATUS, 32'h80);
        fl[7] = 1'b0;
        ev('{rx_poll: 1'b1, default: 1'b0});
        rs = 3'h1;
        rds();
        ev('{rx_desc_fetched: 1'b1, rx_desc_host_owned: 1'b1, default: 1'b0});
        rs = 3'h6;
        rds();
        ev('{rx_frame_seen: 1'b1, default: 1'b0});
        rs = 3'h1;
        rds();
        ev('{rx_watchdog: 1'b1, default: 1'b0});
        fl[9] = 1'b1;
        rds();
        bus(1'b1, DSEF_OFF_CTRL, 32'h2);
        fl[8] = 1'b1;
        rs = 3'h0;
        rds();
        $display("test receive done");
        ev('{tx_desc_fetched: 1'b1, tx_desc_host_owned: 1'b1, default: 1'b0});
        fl[2] = 1'b1;
        ts = 3'h6;
        rds();
        ev('{tx_poll: 1'b1, default: 1'b0});
        ts = 3'h1;
        rds();
        ev('{tx_desc_fetched: 1'b1, default: 1'b0});
        ev('{tx_fifo_underflow: 1'b1, default: 1'b0});
        fl[5] = 1'b1;
        ts = 3'h6;
        rds();
        check({31'h0, dword[DSEF_TDS_UNF]}, 32'h1, "underflow mark");
        bus(1'b1, DSEF_OFF_CTRL, 32'h6);
        ts = 3'h1;
        rds();
        ev('{tx_desc_fetched: 1'b1, default: 1'b0});
        ev('{tx_frame_done: 1'b1, default: 1'b0});
        fl[0] = 1'b1;
        rds();
        ev('{tx_desc_fetched: 1'b1, default: 1'b0});
        ev('{tx_jabber: 1'b1, default: 1'b0});
        fl[3] = 1'b1;
        fl[1] = 1'b1;
        ts = 3'h0;
        rds();
        check({31'h0, dword[DSEF_TDS_JAB]}, 32'h1, "jabber mark");
        $display("test transmit done");
        bus(1'b1, DSEF_OFF_STATUS, 32'h0);
        rds();
        bus(1'b1, DSEF_OFF_STATUS, 32'hffffffff);
        fl = 17'h0;
        rds();
        $display("test clearing done");
        // An event pulse while the clock enable is low must leave no trace
        @(posedge clk);
        en <= 1'b0;
        ev('{rx_watchdog: 1'b1, default: 1'b0});
        en <= 1'b1;
        rds();
        $display("test clock enable done");
        report_and_stop();
    end
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule
